/* File: src/eic_pkg.sv */
//
// Behaviour
// - Bit 15 of each word is the format flag: zero means plain unsigned, one means decimal float.
// - With the flag clear the whole word is an unscaled unsigned integer.
// - With the flag set the value is the signed mantissa times ten to the signed exponent.
// - The exponent is four bits of two's complement, from -8 to +7.
// - The mantissa is eleven bits of two's complement, from -1024 to +1023.
// - In float form the flag sits at bit 15, the exponent at 14..11 and the mantissa at 10..0.
// - The device may round a written value to the significant digits it keeps.
// - The float form holds large or small magnitudes in one word with three significant digits.
// - A read may answer in either form, so the reader must check the flag and decode both.
// - This word coding applies only to parameter exchange over the two serial-register links.
package eic_pkg;

    // ****************************************
    // Word layout
    // ****************************************
    localparam int EIC_FLAG_POS = 15;
    localparam int EIC_EXP_LSB = 11;
    localparam int EIC_MAN_LSB = 0;
    localparam logic [15:0] EIC_WORD_RST = 16'h0000;
    localparam logic [31:0] EIC_PLAIN_MAX = 32'h0000_7FFF;
    localparam logic [31:0] EIC_MAG_LIMIT = 32'h0000_03E8;
    localparam logic signed [4:0] EIC_EXP_MAX = 5'sh07;

    // Float form of the word
    typedef struct packed {
        logic flag;
        logic signed [3:0] expo;
        logic signed [10:0] mant;
    } eic_word_type;

    // Encoder input: signed integer times ten to a signed scale
    typedef struct packed {
        logic signed [31:0] value;
        logic signed [4:0] scale;
    } eic_num_type;

endpackage : eic_pkg

/* File: src/eic_codec.sv */
`timescale 1ns/1ps
// ****************************************
// Extended integer word encoder and decoder
// ****************************************
module eic_codec
    import eic_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Encode request
    input wire logic enc_start_i,
    input wire eic_num_type enc_num_i,
    output logic enc_busy_o,
    output logic enc_done_o,
    output logic [15:0] enc_word_o,
    // Decode request
    input wire logic dec_start_i,
    input wire logic [15:0] dec_word_i,
    output logic dec_done_o,
    output logic dec_is_float_o,
    output logic [14:0] dec_plain_unsigned_word_o,
    output logic signed [10:0] dec_mant_o,
    output logic signed [3:0] dec_exp_o
);

    // ****************************************
    // Encoder state and datapath
    // ****************************************

    typedef enum logic [1:0] {ENC_IDLE, ENC_SCALE, ENC_ROUND} eic_enc_state_type;

    eic_enc_state_type state_q;
    logic [31:0] mag_q;
    logic neg_q;
    logic signed [4:0] exp_q;
    logic rem_half_q;
    logic [15:0] word_q;
    logic done_q;
    logic busy_q;
    logic plain_req;
    logic scale_more;
    logic [31:0] mag_abs;
    logic [31:0] mag_rnd;
    logic signed [10:0] man_s;
    eic_word_type fword;

    // Magnitude of the request
    assign mag_abs = enc_num_i.value[31] ? 32'(-enc_num_i.value) : enc_num_i.value;
    // Round half up from the last digit dropped
    assign mag_rnd = mag_q + {31'h0000_0000, rem_half_q};
    assign man_s = neg_q ? 11'(-mag_rnd) : 11'(mag_rnd);

    // Float form assembly
    always_comb begin
        fword.flag = 1'b1;
        fword.expo = 4'(exp_q);
        fword.mant = man_s;
    end

    // Whole non-negative numbers up to 32767 fit the plain form
    assign plain_req = (enc_num_i.scale == 5'sh00) && !enc_num_i.value[31]
        && (enc_num_i.value <= $signed(EIC_PLAIN_MAX));
    // Another division is due while too many digits remain and the exponent is below 7
    assign scale_more = (mag_q > EIC_MAG_LIMIT) && (exp_q < EIC_EXP_MAX);

    // ****************************************
    // Encoder sequencer
    // ****************************************

    // Plain words finish from idle, others scale and then round
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ENC_IDLE;
        end else begin
            case (state_q)
                ENC_IDLE: begin
                    if (enc_start_i && !plain_req) begin
                        state_q <= ENC_SCALE;
                    end
                end
                ENC_SCALE: begin
                    if (!scale_more) begin
                        state_q <= ENC_ROUND;
                    end
                end
                ENC_ROUND: begin
                    state_q <= ENC_IDLE;
                end
                default: begin
                    state_q <= ENC_IDLE;
                end
            endcase
        end
    end

    // Magnitude, sign, exponent and last dropped digit
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mag_q <= 32'h0000_0000;
            neg_q <= 1'b0;
            exp_q <= 5'sh00;
            rem_half_q <= 1'b0;
        end else if (state_q == ENC_IDLE) begin
            if (enc_start_i) begin
                neg_q <= enc_num_i.value[31];
                mag_q <= mag_abs;
                exp_q <= enc_num_i.scale;
                rem_half_q <= 1'b0;
            end
        end else if (state_q == ENC_SCALE && scale_more) begin
            // One decimal digit dropped per cycle
            mag_q <= mag_q / 32'd10;
            rem_half_q <= (mag_q % 32'd10) >= 32'd5;
            exp_q <= exp_q + 5'sh01;
        end
    end

    // ****************************************
    // Encoder results
    // ****************************************

    // Result word: plain at once, float after rounding
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_q <= EIC_WORD_RST;
        end else if (state_q == ENC_IDLE && enc_start_i && plain_req) begin
            word_q <= enc_num_i.value[15:0];
        end else if (state_q == ENC_ROUND) begin
            word_q <= fword;
        end
    end

    // Done pulse, one cycle with each new word
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == ENC_IDLE && enc_start_i && plain_req)
                || (state_q == ENC_ROUND);
        end
    end

    // Busy flag, high while scaling or rounding
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_q == ENC_IDLE && enc_start_i && !plain_req)
                || (state_q == ENC_SCALE);
        end
    end

    // Encoder outputs straight from flops
    assign enc_busy_o = busy_q;
    assign enc_done_o = done_q;
    assign enc_word_o = word_q;

    // ****************************************
    // Decoder
    // ****************************************

    logic dec_done_q;
    logic dec_float_q;
    logic [14:0] dec_plain_q;
    logic signed [10:0] dec_mant_q;
    logic signed [3:0] dec_exp_q;

    // Decoder: capture the flag and both readings of the word on each start
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dec_done_q <= 1'b0;
            dec_float_q <= 1'b0;
            dec_plain_q <= 15'h0000;
            dec_mant_q <= 11'sh000;
            dec_exp_q <= 4'sh0;
        end else begin
            dec_done_q <= dec_start_i;
            if (dec_start_i) begin
                dec_float_q <= dec_word_i[EIC_FLAG_POS];
                dec_plain_q <= dec_word_i[14:0];
                dec_exp_q <= dec_word_i[EIC_EXP_LSB +: 4];
                dec_mant_q <= dec_word_i[EIC_MAN_LSB +: 11];
            end
        end
    end

    // ****************************************
    // Decoder outputs
    // ****************************************

    // Decoded fields straight from flops
    assign dec_done_o = dec_done_q;
    assign dec_is_float_o = dec_float_q;
    assign dec_plain_unsigned_word_o = dec_plain_q;
    assign dec_mant_o = dec_mant_q;
    assign dec_exp_o = dec_exp_q;

endmodule : eic_codec

/* File: bench/eic_codec_properties.sv */
`timescale 1ns/1ps
module eic_codec_properties
    import eic_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic enc_start_i,
    input wire eic_num_type enc_num_i,
    input wire logic enc_busy_o,
    input wire logic enc_done_o,
    input wire logic [15:0] enc_word_o,
    input wire logic dec_start_i,
    input wire logic [15:0] dec_word_i,
    input wire logic dec_done_o,
    input wire logic dec_is_float_o,
    input wire logic [14:0] dec_plain_unsigned_word_o,
    input wire logic signed [10:0] dec_mant_o,
    input wire logic signed [3:0] dec_exp_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Taken and plain encode requests
    wire logic tk = enc_start_i && !enc_busy_o;
    wire logic pl = tk && enc_num_i.scale == 0 && enc_num_i.value inside {[0:32767]};
    a_plain_word: assert property (pl |=> enc_done_o &&
        enc_word_o == {1'b0, $past(enc_num_i.value[14:0])}) else $error("plain");
    a_enc_bound: assert property (tk |=> ##[0:11] enc_done_o)
        else $error("late");
    a_word_hold: assert property (!enc_done_o |-> $stable(enc_word_o))
        else $error("hold");
    a_dec_done: assert property (dec_start_i |=> dec_done_o) else $error("dec");
    a_dec_quiet: assert property (!dec_start_i |=> !dec_done_o) else $error("spur");
    a_dec_flag: assert property (dec_start_i |=> dec_is_float_o == $past(dec_word_i[15]))
        else $error("flag");
    a_dec_plain: assert property (dec_start_i |=>
        dec_plain_unsigned_word_o == $past(dec_word_i[14:0])) else $error("plain");
    a_dec_fields: assert property (dec_start_i |=>
        {dec_exp_o, dec_mant_o} == $past(dec_word_i[14:0])) else $error("fields");
    cover property (tk && !pl);
    cover property (pl ##1 pl);
    cover property (dec_start_i [*3]);
endmodule : eic_codec_properties
bind eic_codec eic_codec_properties u_props (.*);

/* File: bench/eic_master.sv */
`timescale 1ns/1ps
// Master side word packing
module eic_master;
    function automatic logic [15:0] float_word(input logic [3:0] e, input logic [10:0] m);
        return {1'b1, e, m};
    endfunction : float_word
    function automatic logic [15:0] plain_word(input logic [14:0] v);
        return {1'b0, v};
    endfunction : plain_word
endmodule : eic_master

/* File: bench/eic_codec_tb.sv */
`timescale 1ns/1ps
module eic_codec_tb
    import eic_pkg::*;
;
    logic core_clk_i = 0, resetn_i = 0, enc_start_i = 0, dec_start_i = 0;
    logic enc_busy_o, enc_done_o, dec_done_o, dec_is_float_o;
    logic [15:0] dec_word_i = '0, enc_word_o, eq[$], dq[$];
    logic [14:0] dec_plain_unsigned_word_o;
    logic signed [10:0] dec_mant_o;
    logic signed [3:0] dec_exp_o;
    logic [31:0] v;
    eic_num_type enc_num_i = '0;
    int num_errors = 0, n_checks = 0;
    logic [52:0] et[7] = '{{32'sd123, -5'sd2, 16'hF07B}, {32'sd32767, 5'sd0, 16'h7FFF},
        {-32'sd5, 5'sd0, 16'h87FB}, {32'sd1005, -5'sd1, 16'h8065}, {32'sd32768, 5'sd0, 16'h9148},
        {32'sd1000, -5'sd3, 16'hEBE8}, {32'sd1001, -5'sd3, 16'hF064}};
    eic_master u_m();
    eic_codec u_dut (.*);
    // Clock
    always #20 core_clk_i = ~core_clk_i;
    task automatic chk(input string n, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic end_sim();
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic put_enc(input logic [52:0] t);
        int c = 0;
        @(negedge core_clk_i);
        while (enc_busy_o !== 1'b0 && c++ < 20) @(negedge core_clk_i);
        if (enc_busy_o !== 1'b0) begin
            num_errors++;
            end_sim();
        end
        {enc_start_i, enc_num_i} = {1'b1, t[52:16]};
        eq.push_back(t[15:0]);
    endtask : put_enc
    // Result watcher
    always @(negedge core_clk_i) begin
        if (enc_done_o === 1'b1)
            chk("enc", eq.pop_front(), enc_word_o);
        if (dec_done_o === 1'b1) begin
            chk("flag", dq[0], {dec_is_float_o, dec_plain_unsigned_word_o});
            chk("fields", dq.pop_front(), {dec_is_float_o, dec_exp_o, dec_mant_o});
        end
    end
    // Reset, encode table, plain run, decode run
    initial begin
        void'($urandom(90477));
        repeat (12) @(negedge core_clk_i);
        resetn_i = 1;
        foreach (et[i]) put_enc(et[i]);
        repeat (6) begin
            v = $urandom_range(32767);
            put_enc({v, 5'd0, 1'b0, v[14:0]});
        end
        for (int i = 0; i < 40; i++) begin
            @(negedge core_clk_i);
            {enc_start_i, dec_start_i} = 2'b01;
            dec_word_i = i[0] ? u_m.float_word(4'(i >> 1), 11'($urandom))
                : u_m.plain_word(15'($urandom));
            dq.push_back(dec_word_i);
        end
        @(negedge core_clk_i) dec_start_i = 0;
        for (int c = 0; c < 50 && eq.size() + dq.size() > 0; c++) @(negedge core_clk_i);
        chk("left", 0, 16'(eq.size() + dq.size()));
        end_sim();
    end
endmodule : eic_codec_tb
